// >>> sim/kcw_fw_model.sv
// Firmware model issuing watchdog register accesses
`timescale 1ns/1ns
module kcw_fw_model
    import kcw_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // External data access
    output kcw_xreq_t xreq
);
    logic [7:0] exp_q[$];
    initial begin
        xreq = '0;
    end
    // One access; address and data are inverted once released
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        xreq <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        xreq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // Read and note the expected data
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask
    // Unlock then load with enable kept set; never sleeps past the interval
    task automatic reload(input logic [7:0] n);
        acc(1'b1, KCW_ADDR_CTRL, 8'h03);
        acc(1'b1, KCW_ADDR_COUNT, n);
    endtask
    // Unlock then write zero to stop the watchdog
    task automatic stop();
        acc(1'b1, KCW_ADDR_CTRL, 8'h01);
        acc(1'b1, KCW_ADDR_COUNT, KCW_COUNT_DISABLE);
    endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the keyboard controller watchdog
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb
    import kcw_pkg::*;
();
    logic sys_clk = 1'b0;
    logic tb_rst = 1'b1;
    logic slow_clk_32k = 1'b0;
    logic pend_q = 1'b0;
    logic reset;
    kcw_xreq_t xreq;
    logic [7:0] xdata_rdata_q;
    logic [7:0] watchdog_counter_q;
    logic [7:0] n;
    logic [7:0] e_q;
    logic watchdog_run_enable_q;
    logic load_unlock_bit_q;
    logic main_plane_power_on_reset_q;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int por_n = 0;
    int t0;
    int dt;
    always #10 sys_clk = ~sys_clk;
    // Slow clock runs free at one eighth of the system clock
    always begin
        repeat (4) @(posedge sys_clk);
        slow_clk_32k <= ~slow_clk_32k;
    end
    // Underflow request is fed back as the main plane reset
    assign reset = tb_rst | main_plane_power_on_reset_q;
    kcw_fw_model kcw_fw_model_i (.sys_clk(sys_clk), .xreq(xreq));
    kcw_watchdog kcw_watchdog_i (
        .sys_clk(sys_clk),
        .reset(reset),
        .slow_clk_32k(slow_clk_32k),
        .xreq(xreq),
        .xdata_rdata_q(xdata_rdata_q),
        .watchdog_run_enable_q(watchdog_run_enable_q),
        .load_unlock_bit_q(load_unlock_bit_q),
        .watchdog_counter_q(watchdog_counter_q),
        .main_plane_power_on_reset_q(main_plane_power_on_reset_q)
    );
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Read data is matched against the oldest noted expectation
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        por_n <= por_n + int'(main_plane_power_on_reset_q);
        if (pend_q) begin
            e_q = kcw_fw_model_i.exp_q.pop_front();
            `CHK("rdata", e_q, xdata_rdata_q)
        end
        pend_q <= xreq.rd;
        if (cyc == 40000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        dt = $urandom(32'h6de11991);
        repeat (20) @(posedge sys_clk);
        tb_rst <= 1'b0;
        @(posedge sys_clk);
        kcw_fw_model_i.rd(KCW_ADDR_CTRL, KCW_CTRL_RESET);
        kcw_fw_model_i.rd(KCW_ADDR_COUNT, KCW_COUNT_RESET);
        kcw_fw_model_i.rd(16'h7f39, 8'h00);
        kcw_fw_model_i.acc(1'b1, KCW_ADDR_COUNT, 8'h55);
        kcw_fw_model_i.rd(KCW_ADDR_COUNT, KCW_COUNT_RESET);
        kcw_fw_model_i.acc(1'b1, KCW_ADDR_CTRL, 8'hfc);
        kcw_fw_model_i.rd(KCW_ADDR_CTRL, 8'h00);
        repeat ($urandom % 300) @(posedge sys_clk);
        n = 8'(2 + $urandom % 3);
        kcw_fw_model_i.reload(n);
        @(posedge sys_clk);
        `CHK("unlock", 1'b0, load_unlock_bit_q)
        `CHK("enable", 1'b1, watchdog_run_enable_q)
        `CHK("counter", n, watchdog_counter_q)
        kcw_fw_model_i.rd(KCW_ADDR_CTRL, 8'h02);
        kcw_fw_model_i.rd(KCW_ADDR_COUNT, n);
        kcw_fw_model_i.acc(1'b1, KCW_ADDR_CTRL, 8'h00);
        kcw_fw_model_i.rd(KCW_ADDR_CTRL, 8'h02);
        repeat (4156) @(posedge sys_clk);
        kcw_fw_model_i.rd(KCW_ADDR_COUNT, n - 8'h01);
        repeat ($urandom % 3000) @(posedge sys_clk);
        kcw_fw_model_i.reload(KCW_COUNT_LAST);
        t0 = cyc;
        while (por_n == 0 && cyc - t0 < 5000) @(posedge sys_clk);
        dt = cyc - t0;
        `CHK("underflow", 1, por_n)
        `CHK("interval", 1'b1, (dt >= 4080 && dt <= 4120))
        repeat (4) @(posedge sys_clk);
        kcw_fw_model_i.rd(KCW_ADDR_CTRL, KCW_CTRL_RESET);
        kcw_fw_model_i.rd(KCW_ADDR_COUNT, KCW_COUNT_RESET);
        kcw_fw_model_i.acc(1'b1, KCW_ADDR_CTRL, 8'h02);
        kcw_fw_model_i.reload(8'h02);
        kcw_fw_model_i.stop();
        kcw_fw_model_i.rd(KCW_ADDR_CTRL, 8'h00);
        kcw_fw_model_i.rd(KCW_ADDR_COUNT, KCW_COUNT_DISABLE);
        `CHK("halted", 1'b0, watchdog_run_enable_q)
        repeat (12600) @(posedge sys_clk);
        `CHK("stopped", 1, por_n)
        `CHK("held", KCW_COUNT_DISABLE, watchdog_counter_q)
        end_of_test();
    end
endmodule

// >>> src/kcw_pkg.sv
// Constants and types shared by the keyboard controller watchdog
package kcw_pkg;
    // Register addresses on the microcontroller external data bus
    localparam logic [15:0] KCW_ADDR_CTRL = 16'h7f37;
    localparam logic [15:0] KCW_ADDR_COUNT = 16'h7f38;
    // Control/status field positions
    localparam int KCW_BIT_UNLOCK = 0;
    localparam int KCW_BIT_ENABLE = 1;
    // Reset values, disable load value and last count before underflow
    localparam logic [7:0] KCW_CTRL_RESET = 8'h00;
    localparam logic [7:0] KCW_COUNT_RESET = 8'hff;
    localparam logic [7:0] KCW_COUNT_DISABLE = 8'h00;
    localparam logic [7:0] KCW_COUNT_LAST = 8'h01;
    // Prescaler: slow clock periods per counter step
    localparam int KCW_PRESCALE_BITS = 9;
    localparam logic [8:0] KCW_PRESCALE_TOP = 9'h1ff;
    localparam logic [8:0] KCW_PRESCALE_RESET = 9'h000;
    // Microcontroller external data access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } kcw_xreq_t;
endpackage

// >>> src/kcw_prescaler.sv
// Nine-bit prescaler: one tick per 512 slow clock edges
`timescale 1ns/1ns
module kcw_prescaler
    import kcw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Slow clock edge and restart
    input wire logic step,
    input wire logic clear,
    // Count and tick
    output logic [KCW_PRESCALE_BITS-1:0] count_q,
    output logic tick_q
);
    logic [KCW_PRESCALE_BITS-1:0] count_d;
    logic tick_d;

    always_comb begin
        count_d = count_q;
        tick_d = 1'b0;
        if (clear) begin
            count_d = KCW_PRESCALE_RESET;
        end else if (step) begin
            if (count_q == KCW_PRESCALE_TOP) begin
                count_d = KCW_PRESCALE_RESET;
                tick_d = 1'b1;
            end else begin
                count_d = count_q + 9'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_q <= KCW_PRESCALE_RESET;
            tick_q <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q <= tick_d;
        end
    end
endmodule

// >>> src/kcw_sync3.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ns
module kcw_sync3
    import kcw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Asynchronous input
    input wire logic async_in,
    // Filtered level and rising edge
    output logic level_q,
    output logic rise_q
);
    logic s1_q, s2_q, s3_q;
    logic level_d, rise_d;

    // Level changes only once stages two and three agree
    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
        rise_d = level_d & ~level_q;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
            rise_q <= rise_d;
        end
    end
endmodule

// >>> src/kcw_watchdog.sv
// Watchdog timer with unlock-then-load reload, top level
// What this block does
// - Eight-bit counter behind nine-bit slow prescaler
// - Counter steps once per 512 slow periods
// - Underflow raises main plane power-on reset
// - Keeps counting while the core idles
// - Power-on reset leaves watchdog disabled
// - Setting enable bit starts counting
// - Unlocked write of zero disables watchdog
// - Counter write needs unlock, then clears it
// - Locked counter writes are ignored
// - Reload value sets interval in ticks
// - Accepted load restarts the prescaler
// - Counter at 7F38, resets to FF
// - Control at 7F37, upper bits read zero
`timescale 1ns/1ns
module kcw_watchdog
    import kcw_pkg::*;
(
    // Clock and main plane reset
    input wire logic sys_clk,
    input wire logic reset,
    // Always-running slow clock pin
    input wire logic slow_clk_32k,
    // Microcontroller external data access
    input wire kcw_xreq_t xreq,
    output logic [7:0] xdata_rdata_q,
    // Watchdog state and reset request
    output logic watchdog_run_enable_q,
    output logic load_unlock_bit_q,
    output logic [7:0] watchdog_counter_q,
    output logic main_plane_power_on_reset_q
);
    logic slow_rise;
    logic tick;
    logic [KCW_PRESCALE_BITS-1:0] presc_count;
    logic wr_ctl, wr_cnt, load_ok, fire;
    logic enable_d, unlock_d, por_d;
    logic [7:0] counter_d, rdata_d;

    // Slow clock comes from a pin and is filtered before use
    kcw_sync3 u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(slow_clk_32k),
        .level_q(),
        .rise_q(slow_rise)
    );

    // Prescaler runs regardless of core idle or sleep
    kcw_prescaler u_presc (
        .sys_clk(sys_clk),
        .reset(reset),
        .step(slow_rise),
        .clear(load_ok),
        .count_q(presc_count),
        .tick_q(tick)
    );

    // Address decode; only the microcontroller port exists
    always_comb begin
        wr_ctl = xreq.wr && (xreq.addr == KCW_ADDR_CTRL);
        wr_cnt = xreq.wr && (xreq.addr == KCW_ADDR_COUNT);
        load_ok = wr_cnt && load_unlock_bit_q;
        fire = watchdog_run_enable_q && tick && (watchdog_counter_q <= KCW_COUNT_LAST);
    end

    // Control/status next state
    always_comb begin
        enable_d = watchdog_run_enable_q;
        unlock_d = load_unlock_bit_q;
        if (wr_ctl) begin
            unlock_d = xreq.wdata[KCW_BIT_UNLOCK];
            if (xreq.wdata[KCW_BIT_ENABLE]) begin
                enable_d = 1'b1;
            end
            // Writing zero to enable leaves it set
        end
        if (load_ok) begin
            unlock_d = 1'b0;
            if (xreq.wdata == KCW_COUNT_DISABLE) begin
                enable_d = 1'b0;
            end
        end
    end

    // Counter and request next state; load wins over a tick in the same cycle for the counter only
    always_comb begin
        counter_d = watchdog_counter_q;
        if (load_ok) begin
            counter_d = xreq.wdata;
        end else if (watchdog_run_enable_q && tick) begin
            if (watchdog_counter_q != KCW_COUNT_DISABLE) begin
                counter_d = watchdog_counter_q - 8'h01;
            end
        end
        por_d = fire;
    end

    // Read data, one cycle after the read strobe
    always_comb begin
        rdata_d = 8'h00;
        if (xreq.rd) begin
            case (xreq.addr)
                KCW_ADDR_CTRL: begin
                    rdata_d = {6'h00, watchdog_run_enable_q, load_unlock_bit_q};
                end
                KCW_ADDR_COUNT: begin
                    rdata_d = watchdog_counter_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            watchdog_run_enable_q <= KCW_CTRL_RESET[KCW_BIT_ENABLE];
            load_unlock_bit_q <= KCW_CTRL_RESET[KCW_BIT_UNLOCK];
            watchdog_counter_q <= KCW_COUNT_RESET;
            main_plane_power_on_reset_q <= 1'b0;
            xdata_rdata_q <= 8'h00;
        end else begin
            watchdog_run_enable_q <= enable_d;
            load_unlock_bit_q <= unlock_d;
            watchdog_counter_q <= counter_d;
            main_plane_power_on_reset_q <= por_d;
            xdata_rdata_q <= rdata_d;
        end
    end

    // Slow edges seen since the prescaler last restarted, for the tick check
    logic [9:0] chk_steps_q;
    logic [9:0] chk_steps_d;

    always_comb begin
        chk_steps_d = chk_steps_q;
        if (load_ok) begin
            chk_steps_d = 10'h000;
        end else if (tick) begin
            chk_steps_d = {9'h000, slow_rise};
        end else if (slow_rise) begin
            chk_steps_d = chk_steps_q + 10'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            chk_steps_q <= 10'h000;
        end else begin
            chk_steps_q <= chk_steps_d;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (1'b0);

    property p_reset_state;
        reset |=> (!watchdog_run_enable_q && !load_unlock_bit_q && watchdog_counter_q == 8'hff
                   && !main_plane_power_on_reset_q);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("Watchdog state wrong after reset");

    property p_locked_ignored;
        disable iff (reset)
        wr_cnt && !load_unlock_bit_q && !watchdog_run_enable_q |=> $stable(watchdog_counter_q);
    endproperty
    a_locked_ignored: assert property (p_locked_ignored)
        else $error("Locked counter write changed the counter");

    property p_load_takes;
        disable iff (reset)
        load_ok |=> (watchdog_counter_q == $past(xreq.wdata)) && !load_unlock_bit_q;
    endproperty
    a_load_takes: assert property (p_load_takes)
        else $error("Unlocked load not taken or unlock not cleared");

    property p_zero_disables;
        disable iff (reset)
        load_ok && xreq.wdata == 8'h00 |=> !watchdog_run_enable_q && !load_unlock_bit_q;
    endproperty
    a_zero_disables: assert property (p_zero_disables)
        else $error("Loading zero did not disable the watchdog");

    property p_enable_sticks;
        disable iff (reset)
        watchdog_run_enable_q && !(load_ok && xreq.wdata == 8'h00) |=> watchdog_run_enable_q;
    endproperty
    a_enable_sticks: assert property (p_enable_sticks)
        else $error("Enable cleared without the disable sequence");

    property p_enable_sets;
        disable iff (reset)
        wr_ctl && xreq.wdata[1] |=> watchdog_run_enable_q;
    endproperty
    a_enable_sets: assert property (p_enable_sets)
        else $error("Enable write did not start the watchdog");

    // Request checks stay live, as the request is fed back as reset
    property p_fire_cause;
        main_plane_power_on_reset_q |->
            $past(watchdog_run_enable_q) && $past(tick) && ($past(watchdog_counter_q) <= 8'h01);
    endproperty
    a_fire_cause: assert property (p_fire_cause)
        else $error("Reset request without an underflow");

    property p_fire_due;
        !reset && watchdog_run_enable_q && tick && watchdog_counter_q == 8'h01 && !load_ok
            |=> main_plane_power_on_reset_q ##1 !main_plane_power_on_reset_q;
    endproperty
    a_fire_due: assert property (p_fire_due)
        else $error("Underflow did not pulse the reset request");

    property p_step;
        disable iff (reset)
        watchdog_run_enable_q && tick && watchdog_counter_q > 8'h01 && !load_ok
            |=> watchdog_counter_q == $past(watchdog_counter_q) - 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("Counter did not step on a tick");

    property p_hold;
        disable iff (reset)
        !tick && !load_ok |=> $stable(watchdog_counter_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Counter moved without a tick or load");

    property p_presc_restart;
        disable iff (reset)
        load_ok |=> presc_count == 9'h000 && !tick;
    endproperty
    a_presc_restart: assert property (p_presc_restart)
        else $error("Load did not restart the prescaler");

    property p_ctl_read;
        disable iff (reset)
        xreq.rd && xreq.addr == 16'h7f37
            |=> xdata_rdata_q == {6'h00, $past(watchdog_run_enable_q), $past(load_unlock_bit_q)};
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("Control read returned wrong value");

    property p_cnt_read;
        disable iff (reset)
        xreq.rd && xreq.addr == 16'h7f38 |=> xdata_rdata_q == $past(watchdog_counter_q);
    endproperty
    a_cnt_read: assert property (p_cnt_read)
        else $error("Counter read returned wrong value");

    property p_por_pulse;
        main_plane_power_on_reset_q |=> !main_plane_power_on_reset_q;
    endproperty
    a_por_pulse: assert property (p_por_pulse)
        else $error("Reset request held longer than one cycle");

    property p_disabled_quiet;
        !watchdog_run_enable_q |=> !main_plane_power_on_reset_q;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("Reset request while the watchdog is disabled");

    property p_rdata_idle;
        disable iff (reset)
        !xreq.rd |=> xdata_rdata_q == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("Read data not zero outside a read");

    property p_unmapped_read;
        disable iff (reset)
        xreq.rd && xreq.addr != KCW_ADDR_CTRL && xreq.addr != KCW_ADDR_COUNT
            |=> xdata_rdata_q == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("Unmapped read returned data");

    property p_unlock_write;
        disable iff (reset)
        wr_ctl |=> load_unlock_bit_q == $past(xreq.wdata[KCW_BIT_UNLOCK]);
    endproperty
    a_unlock_write: assert property (p_unlock_write)
        else $error("Control write did not set the unlock bit");

    property p_tick_period;
        disable iff (reset)
        tick |-> chk_steps_q == ({1'b0, KCW_PRESCALE_TOP} + 10'h001);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("Prescaler tick not after a full run of slow edges");

    property p_cov_load;
        disable iff (reset)
        load_ok && xreq.wdata != 8'h00;
    endproperty
    c_cov_load: cover property (p_cov_load);

    property p_cov_fire;
        main_plane_power_on_reset_q;
    endproperty
    c_cov_fire: cover property (p_cov_fire);

    property p_cov_disable;
        disable iff (reset)
        watchdog_run_enable_q ##1 !watchdog_run_enable_q;
    endproperty
    c_cov_disable: cover property (p_cov_disable);

    property p_cov_locked;
        disable iff (reset)
        wr_cnt && !load_unlock_bit_q;
    endproperty
    c_cov_locked: cover property (p_cov_locked);
endmodule
